// ==== hw/pscl_pkg.sv ====
// Constants shared by the passive serial configuration loader
// Functional notes
// - First chip-select grounded; chain output feeds next
// - Chain output low when load completes
// - Shared request, status, clock, data, done lines
// - Detected error pulls shared status low
// - Auto-restart releases status within 40 us
// - User clock option paces entry to user mode
// - Identical data: all chip-selects grounded together
// - Chain output stays dedicated after configuration unless strapped as user I/O
// - Request low drives done, status low within 800 ns
// - Status released within 40 us, low 10 us
// - Internal oscillator: user mode 18 to 40 us
// - User clock: 4 clock periods plus 299 cycles; loader enters user mode after 299 user clock edges counted from done
// - Power-up holds status low 100 ms
// - Done held low until configuration completes
// - User mode: all lines high; request low restarts; chain output stays low here unless strapped as user I/O
// - Data sampled on rising load clock edge
// - Done released after all data received
package pscl_pkg;

  // Reference clock period in ns
  localparam int unsigned CLK_PERIOD_NS   = 50;
  // Documented times
  localparam int unsigned STATUS_LOW_US   = 10;
  localparam int unsigned RESTART_US      = 40;
  localparam int unsigned USER_MODE_US    = 18;
  localparam int unsigned POR_MS          = 100;
  localparam int unsigned REQ_FALL_NS     = 800;
  // Cycle counts: least times round up
  localparam int unsigned STATUS_LOW_CYC  =
    (STATUS_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned USER_MODE_CYC   =
    (USER_MODE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Longest times round down
  localparam int unsigned RESTART_CYC     =
    (RESTART_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned POR_CYC_DEF     =
    (POR_MS * 1000 * 1000) / CLK_PERIOD_NS;
  // User clock edges to user mode, counted once init begins; init
  // starts earlier than the 4-period user clock start-up after done
  localparam int unsigned USER_CLK_CYC    = 299;
  // Configuration image length in bits (plain default)
  localparam int unsigned IMAGE_BITS_DEF  = 64;
  // FIFO shape
  localparam int unsigned FIFO_WIDTH      = 8;
  localparam int unsigned FIFO_DEPTH      = 8;
  // Width of the general timer
  localparam int unsigned TMR_W           = 22;

  // Loader sequence
  typedef enum logic [2:0] {
    ST_POR    = 3'b000,
    ST_RESET  = 3'b001,
    ST_WAIT   = 3'b010,
    ST_LOAD   = 3'b011,
    ST_PASS   = 3'b100,
    ST_INIT   = 3'b101,
    ST_USER   = 3'b110,
    ST_ERROR  = 3'b111
  } pscl_state_type;

endpackage : pscl_pkg

// ==== hw/pscl_fifo.sv ====
// Small synchronous FIFO for configuration bytes
`timescale 1ns/1ps
`default_nettype none
module pscl_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];    // Storage
  logic [AW-1:0]    wr_ptr_reg;     // Write index
  logic [AW-1:0]    rd_ptr_reg;     // Read index
  logic [AW:0]      count_reg;      // Fill level
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and level
  always_ff @(posedge ref_clk) begin
    if (rst || flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : pscl_fifo
`default_nettype wire

// ==== hw/pscl_loader.sv ====
// Passive serial configuration loader of one chained device
`timescale 1ns/1ps
`default_nettype none
module pscl_loader import pscl_pkg::*; #(
  parameter int unsigned POR_CYC    = POR_CYC_DEF,
  parameter int unsigned IMAGE_BITS = IMAGE_BITS_DEF
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Configuration pins from the host
  input  wire logic        config_req_n_in,
  input  wire logic        serial_load_clock,
  input  wire logic        serial_load_data,
  input  wire logic        chip_select_in_n,
  input  wire logic        user_init_clock,
  // Shared open-drain status line
  input  wire logic        status_n_in,
  output logic             status_n_out,
  output logic             status_n_oe,
  // Shared open-drain done line
  input  wire logic        done_in,
  output logic             done_out,
  output logic             done_oe,
  // Chain output to the next device
  output logic             chain_enable_out_n,
  // Option straps
  input  wire logic        auto_restart_en,
  input  wire logic        user_clock_en,
  input  wire logic        chain_out_user_io,
  input  wire logic        chain_out_user_val,
  // Core side
  output logic             user_mode,
  output logic [7:0]       cfg_byte,
  output logic             cfg_byte_valid,
  input  wire logic        cfg_byte_ready,
  input  wire logic        cfg_error
);
  // Two-stage synchronisers
  logic [1:0] req_sync_reg;
  logic [1:0] serial_load_clock_sync_reg;
  logic [1:0] data_sync_reg;
  logic [1:0] ce_sync_reg;
  logic [1:0] uclk_sync_reg;
  logic [1:0] status_sync_reg;
  logic [1:0] done_sync_reg;
  logic       serial_load_clock_prev_reg;        // Last synced load clock
  logic       uclk_prev_reg;        // Last synced user clock
  logic       serial_load_clock_rise;
  logic       uclk_rise;
  logic       req_n;
  logic       status_line;
  logic       done_line;

  // State and counters
  pscl_state_type state_reg;
  logic [TMR_W-1:0] tmr_reg;        // Time in state
  logic [31:0]      por_reg;        // Power-on delay
  logic [31:0]      bit_cnt_reg;    // Bits taken
  logic [8:0]       ucnt_reg;       // User clock edges
  logic [2:0]       sh_cnt_reg;     // Bit in byte
  logic [7:0]       sh_reg;         // Byte assembly
  logic             byte_push_reg;  // Byte ready for FIFO
  logic             fifo_in_ready;
  logic             fifo_flush;
  logic             fifo_valid;
  logic [7:0]       fifo_data;
  logic             fifo_overflow;  // Byte lost to a full buffer

  // Synchronise every host and shared-line pin; option straps are used directly
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      req_sync_reg    <= 2'b11;
      serial_load_clock_sync_reg   <= 2'b00;
      data_sync_reg   <= 2'b00;
      ce_sync_reg     <= 2'b11;
      uclk_sync_reg   <= 2'b00;
      status_sync_reg <= 2'b00;
      done_sync_reg   <= 2'b00;
    end else begin
      req_sync_reg    <= {req_sync_reg[0], config_req_n_in};
      serial_load_clock_sync_reg   <= {serial_load_clock_sync_reg[0], serial_load_clock};
      data_sync_reg   <= {data_sync_reg[0], serial_load_data};
      ce_sync_reg     <= {ce_sync_reg[0], chip_select_in_n};
      uclk_sync_reg   <= {uclk_sync_reg[0], user_init_clock};
      status_sync_reg <= {status_sync_reg[0], status_n_in};
      done_sync_reg   <= {done_sync_reg[0], done_in};
    end
  end

  // Edge memory for clocks taken from pins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      serial_load_clock_prev_reg <= 1'b0;
      uclk_prev_reg <= 1'b0;
    end else begin
      serial_load_clock_prev_reg <= serial_load_clock_sync_reg[1];
      uclk_prev_reg <= uclk_sync_reg[1];
    end
  end

  assign serial_load_clock_rise   = serial_load_clock_sync_reg[1] && !serial_load_clock_prev_reg;
  assign uclk_rise   = uclk_sync_reg[1] && !uclk_prev_reg;
  assign req_n       = req_sync_reg[1];
  assign status_line = status_sync_reg[1];
  assign done_line   = done_sync_reg[1];

  // Power-on delay counter
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      por_reg <= '0;
    end else if (state_reg == ST_POR && por_reg < POR_CYC) begin
      por_reg <= por_reg + 1'b1;
    end
  end

  // Main sequence
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= ST_POR;
      tmr_reg   <= '0;
    end else if (state_reg != ST_POR && !req_n) begin
      // Request low restarts from any state except power-up
      state_reg <= ST_RESET;
      tmr_reg   <= '0;
    end else begin
      tmr_reg <= (&tmr_reg) ? tmr_reg : tmr_reg + 1'b1;
      case (state_reg)
        ST_POR: begin
          // Status held low for the whole power-on delay
          if (por_reg >= POR_CYC) begin
            state_reg <= ST_RESET;
            tmr_reg   <= '0;
          end
        end
        ST_RESET: begin
          // Request is high here; status low at least 10 us
          if (tmr_reg >= TMR_W'(STATUS_LOW_CYC - 1)) begin
            state_reg <= ST_WAIT;
            tmr_reg   <= '0;
          end
        end
        ST_WAIT: begin
          // Wait until every device lets status rise
          if (status_line) begin
            state_reg <= ce_sync_reg[1] ? ST_WAIT : ST_LOAD;
            tmr_reg   <= '0;
          end
        end
        ST_LOAD: begin
          // Lost status, core error or lost byte stops the load
          if (!status_line || cfg_error || fifo_overflow) begin
            state_reg <= ST_ERROR;
            tmr_reg   <= '0;
          end else if (serial_load_clock_rise &&
                       bit_cnt_reg == IMAGE_BITS - 1) begin
            // Last bit of the image taken
            state_reg <= ST_PASS;
            tmr_reg   <= '0;
          end
        end
        ST_PASS: begin
          // Others in the chain still loading; shared done rises
          if (!status_line || fifo_overflow) begin
            state_reg <= ST_ERROR;
            tmr_reg   <= '0;
          end else if (done_line) begin
            state_reg <= ST_INIT;
            tmr_reg   <= '0;
          end
        end
        ST_INIT: begin
          if (user_clock_en) begin
            // Paced by the user clock alone
            if (ucnt_reg >= 9'(USER_CLK_CYC)) begin
              state_reg <= ST_USER;
            end
          end else if (tmr_reg >= TMR_W'(USER_MODE_CYC)) begin
            // Internal oscillator: fixed wait after done rose
            state_reg <= ST_USER;
          end
        end
        ST_USER: begin
          // Left only when the request falls
          state_reg <= ST_USER;
        end
        ST_ERROR: begin
          // Auto-restart releases status after the time-out
          if (auto_restart_en &&
              tmr_reg >= TMR_W'(RESTART_CYC - 1)) begin
            state_reg <= ST_WAIT;
            tmr_reg   <= '0;
          end
        end
        default: begin
          // Unused code: start over from power-up
          state_reg <= ST_POR;
        end
      endcase
    end
  end

  // Bit counter and byte assembly
  always_ff @(posedge ref_clk) begin
    if (rst || state_reg == ST_RESET || state_reg == ST_WAIT) begin
      bit_cnt_reg   <= '0;
      sh_cnt_reg    <= '0;
      sh_reg        <= '0;
      byte_push_reg <= 1'b0;
    end else begin
      // Push strobe lasts one cycle
      byte_push_reg <= 1'b0;
      if (state_reg == ST_LOAD && serial_load_clock_rise) begin
        // Bits arrive least significant first
        sh_reg      <= {data_sync_reg[1], sh_reg[7:1]};
        sh_cnt_reg  <= sh_cnt_reg + 1'b1;
        bit_cnt_reg <= bit_cnt_reg + 1'b1;
        if (sh_cnt_reg == 3'h7) begin
          byte_push_reg <= 1'b1;
        end
      end
    end
  end

  // User clock edges counted after done rises
  always_ff @(posedge ref_clk) begin
    if (rst || state_reg != ST_INIT) begin
      ucnt_reg <= '0;
    end else if (uclk_rise && ucnt_reg != 9'h1_FF) begin
      // Saturates instead of wrapping
      ucnt_reg <= ucnt_reg + 1'b1;
    end
  end

  // Pin drivers, all from flops
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_n_out       <= 1'b0;
      status_n_oe        <= 1'b1;
      done_out           <= 1'b0;
      done_oe            <= 1'b1;
      chain_enable_out_n <= 1'b1;
      user_mode          <= 1'b0;
    end else begin
      // Status held low in power-up, reset and error
      status_n_out <= 1'b0;
      status_n_oe  <= (state_reg == ST_POR || state_reg == ST_ERROR ||
                       (state_reg == ST_RESET) || !req_n);
      // Done held low until own image is complete
      done_out <= 1'b0;
      done_oe  <= !(state_reg == ST_PASS || state_reg == ST_INIT ||
                    state_reg == ST_USER) || !req_n;
      // Chain output low once own load finished
      if (state_reg == ST_USER && chain_out_user_io) begin
        // Strap frees the pin only in user mode
        chain_enable_out_n <= chain_out_user_val;
      end else begin
        chain_enable_out_n <= !(state_reg == ST_PASS ||
                                state_reg == ST_INIT ||
                                state_reg == ST_USER);
      end
      user_mode <= (state_reg == ST_USER) && req_n;
    end
  end

  // A request restart drops bytes of the broken image; auto-restart keeps them
  assign fifo_flush = (state_reg == ST_RESET);

  // Byte buffer toward the core
  pscl_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .flush     (fifo_flush),
    .in_valid  (byte_push_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (sh_reg),
    .out_valid (fifo_valid),
    .out_ready (cfg_byte_ready && !cfg_byte_valid),
    .out_data  (fifo_data)
  );

  // Output stage of the buffer; overflow is a load error
  always_ff @(posedge ref_clk) begin
    if (rst || fifo_flush) begin
      cfg_byte       <= '0;
      cfg_byte_valid <= 1'b0;
    end else if (!cfg_byte_valid && fifo_valid && cfg_byte_ready) begin
      // Take one byte while the core is ready
      cfg_byte       <= fifo_data;
      cfg_byte_valid <= 1'b1;
    end else begin
      // Strobe drops after one cycle
      cfg_byte_valid <= 1'b0;
    end
  end

  // Core stall overflowing the buffer counts as a load error
  assign fifo_overflow = byte_push_reg && !fifo_in_ready;
endmodule : pscl_loader
`default_nettype wire

// ==== tb/pscl_checker.sv ====
// Pin-level assertions for the serial configuration loader
`timescale 1ns/1ps
`default_nettype none
module pscl_checker import pscl_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Pins and straps
  input wire logic config_req_n_in,
  input wire logic user_init_clock,
  input wire logic status_n_out,
  input wire logic status_n_oe,
  input wire logic done_in,
  input wire logic done_out,
  input wire logic done_oe,
  input wire logic chain_enable_out_n,
  input wire logic auto_restart_en,
  input wire logic user_clock_en,
  // Core side
  input wire logic user_mode,
  input wire logic cfg_byte_valid
);
  localparam int UM_MAX = 40 * 1000 / CLK_PERIOD_NS; // Latest user mode
  localparam int REQ_MAX = REQ_FALL_NS / CLK_PERIOD_NS - 1; // Pull limit
  logic [15:0] done_cnt_reg; // Cycles with done line high
  logic [15:0] uclk_cnt_reg; // User clock rises since done rose
  logic [15:0] low_cnt_reg;  // Cycles status pulled low
  logic [15:0] rel_cnt_reg;  // Same, counted with request high
  logic [1:0]  uclk_reg;     // User clock samples
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Time and user clock rises since the done line rose
  always_ff @(posedge ref_clk) begin
    uclk_reg <= {uclk_reg[0], user_init_clock};
    if (rst || !done_in) begin
      done_cnt_reg <= 16'h0000;
      uclk_cnt_reg <= 16'h0000;
    end else begin
      done_cnt_reg <= done_cnt_reg + 16'h0001;
      uclk_cnt_reg <= uclk_cnt_reg + 16'(uclk_reg == 2'b01);
    end
  end
  // Length of the status pull, in total and after request rose
  always_ff @(posedge ref_clk) begin
    low_cnt_reg <= (rst || !status_n_oe) ? 16'h0000 : low_cnt_reg + 16'h0001;
    rel_cnt_reg <= (rst || !status_n_oe || !config_req_n_in) ? 16'h0000
                   : rel_cnt_reg + 16'h0001;
  end
  property p_req_pull;
    $fell(config_req_n_in) |-> ##[1:REQ_MAX] (status_n_oe && done_oe);
  endproperty
  a_req_pull: assert property (p_req_pull)
    else $error("Request low not followed by both pulls");
  property p_req_user;
    $fell(config_req_n_in) |-> ##[1:REQ_MAX] !user_mode;
  endproperty
  a_req_user: assert property (p_req_user)
    else $error("User mode kept after request low");
  property p_open_drain;
    !status_n_out && !done_out;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("Shared line driven high");
  property p_stat_min;
    $fell(status_n_oe) |-> low_cnt_reg >= STATUS_LOW_CYC;
  endproperty
  a_stat_min: assert property (p_stat_min)
    else $error("Status low pulse too short");
  property p_stat_max;
    auto_restart_en && status_n_oe |-> rel_cnt_reg <= RESTART_CYC + 8;
  endproperty
  a_stat_max: assert property (p_stat_max)
    else $error("Status held low too long");
  property p_done_chain;
    $fell(done_oe) |-> !chain_enable_out_n;
  endproperty
  a_done_chain: assert property (p_done_chain)
    else $error("Done released before chain output low");
  property p_user_osc;
    $rose(user_mode) && !user_clock_en |->
      done_cnt_reg >= USER_MODE_CYC - 2 && done_cnt_reg <= UM_MAX;
  endproperty
  a_user_osc: assert property (p_user_osc)
    else $error("User mode outside its window");
  property p_user_clk;
    $rose(user_mode) && user_clock_en |->
      uclk_cnt_reg >= USER_CLK_CYC && uclk_cnt_reg <= USER_CLK_CYC + 2;
  endproperty
  a_user_clk: assert property (p_user_clk)
    else $error("User mode at wrong user clock count");
  property p_user_lines;
    user_mode |-> !status_n_oe && !done_oe;
  endproperty
  a_user_lines: assert property (p_user_lines)
    else $error("Line pulled low in user mode");
  property p_byte_load;
    cfg_byte_valid |-> !user_mode;
  endproperty
  a_byte_load: assert property (p_byte_load)
    else $error("Byte delivered in user mode");
  // Main scenarios reached
  c_user: cover property ($rose(user_mode));
  c_chain: cover property ($fell(chain_enable_out_n));
  c_error: cover property ($rose(status_n_oe) && config_req_n_in);
endmodule : pscl_checker
bind pscl_loader pscl_checker u_chk (.*);
`default_nettype wire

// ==== tb/pscl_host.sv ====
// Behavioural configuration host on the serial load pins
`timescale 1ns/1ps
`default_nettype none
module pscl_host (
  // Pins toward the device
  output logic      config_req_n,
  output logic      load_clk,
  output logic      load_data,
  // Shared status line level
  input  wire logic status_n
);
  realtime t_req; // When the request last rose
  initial begin
    config_req_n = 1'b1;
    load_clk = 1'b0;
    load_data = 1'b0;
    t_req = 0;
  end
  // Low pulse on the request line, then high again
  task automatic pulse_req(input int low_ns);
    config_req_n = 1'b0;
    #(low_ns);
    config_req_n = 1'b1;
    t_req = $realtime;
  endtask
  // Wait for status high, then keep both start delays
  task automatic wait_ready(output bit ok);
    int n;
    ok = 1'b0;
    for (n = 0; n < 4000 && !ok; n++) begin
      #50;
      ok = status_n;
    end
    #1000;
    while ($realtime - t_req < 40000.0) #50;
  endtask
  // One byte, low bit first; data stays driven after it
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      load_data = b[i];
      #200;
      load_clk = 1'b1;
      #200;
      load_clk = 1'b0;
    end
  endtask
endmodule : pscl_host
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the serial configuration loader
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int IMG = 12; // Image length in bytes
  logic       ref_clk, rst, cs_n, uclk, uclk_run, auto_en, uclk_en;
  logic       err, rdy, mon_on, cio, cval;
  wire logic  req_n, lclk, ldata, st_oe, st_out, dn_oe, dn_out, chain_n;
  wire logic  umode, valid;
  wire logic [7:0] cbyte;
  wire logic  status_n = !st_oe; // Pull-up on status
  wire logic  done_line = !dn_oe; // Pull-up on done
  int         n_fail, checked;
  logic [7:0] exp_q[$]; // Bytes the core should see
  always #25 ref_clk = ~ref_clk;
  always #200 if (uclk_run) uclk = ~uclk;
  always @(posedge ref_clk) rdy <= #1 1'($urandom_range(1, 0));
  pscl_host host (.config_req_n(req_n), .load_clk(lclk), .load_data(ldata),
                  .status_n(status_n));
  pscl_loader #(.POR_CYC(50), .IMAGE_BITS(IMG * 8)) uut (
    .ref_clk(ref_clk), .rst(rst), .config_req_n_in(req_n),
    .serial_load_clock(lclk), .serial_load_data(ldata),
    .chip_select_in_n(cs_n), .user_init_clock(uclk),
    .status_n_in(status_n), .status_n_out(st_out), .status_n_oe(st_oe),
    .done_in(done_line), .done_out(dn_out), .done_oe(dn_oe),
    .chain_enable_out_n(chain_n), .auto_restart_en(auto_en),
    .user_clock_en(uclk_en), .chain_out_user_io(cio),
    .chain_out_user_val(cval), .user_mode(umode), .cfg_byte(cbyte),
    .cfg_byte_valid(valid), .cfg_byte_ready(rdy), .cfg_error(err));
  task automatic chk1(string nm, logic e, logic g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1
  task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8
  task automatic print_verdict;
    if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  // Bounded wait for user mode (0) or status high (1)
  task automatic wait_on(int s, int maxc);
    int n;
    for (n = 0; n < maxc && (s ? status_n : umode) !== 1'b1; n++) tick(1);
    if (n == maxc) begin
      n_fail++;
      print_verdict();
    end
  endtask : wait_on
  task automatic do_reset(logic a, logic u);
    rst = 1'b1;
    auto_en = a;
    uclk_en = u;
    tick(20);
    rst = 1'b0;
  endtask : do_reset
  // Model: every delivered byte must be the next one sent
  always @(posedge ref_clk)
    if (valid === 1'b1 && mon_on) begin
      chk8("byte", exp_q.size() ? exp_q[0] : 8'hxx, cbyte);
      if (exp_q.size()) void'(exp_q.pop_front());
    end
  task automatic load(int nb);
    logic [7:0] b;
    bit         ok;
    host.wait_ready(ok);
    chk1("status free", 1'b1, logic'(ok));
    repeat (nb) begin
      b = 8'($urandom);
      if (mon_on && !cs_n) exp_q.push_back(b);
      host.send_byte(b);
    end
    tick(20);
  endtask : load
  // Error mid-image, then check the pull on status
  task automatic break_load;
    mon_on = 1'b0;
    load(3);
    err = 1'b1;
    tick(4);
    err = 1'b0;
    chk1("status pull", 1'b1, st_oe);
  endtask : break_load
  initial begin
    {ref_clk, uclk, uclk_run, err, rdy} = 5'h00;
    {cs_n, mon_on} = 2'b11;
    {cio, cval} = 2'b00;
    n_fail = 0;
    checked = 0;
    void'($urandom(32'hb945));
    do_reset(1'b1, 1'b0);
    chk1("status pull", 1'b1, st_oe);
    chk1("done pull", 1'b1, dn_oe);
    load(1);
    cs_n = 1'b0;
    load(IMG);
    chk1("chain out", 1'b0, chain_n);
    chk1("done pull", 1'b0, dn_oe);
    wait_on(0, 1000);
    chk1("status pull", 1'b0, st_oe);
    chk8("bytes left", 8'h00, 8'(exp_q.size()));
    fork
      host.pulse_req(2000);
      begin
        tick(pscl_pkg::REQ_FALL_NS / pscl_pkg::CLK_PERIOD_NS - 1);
        chk1("done pull", 1'b1, dn_oe);
        chk1("user mode", 1'b0, umode);
      end
    join
    break_load();
    wait_on(1, 900);
    mon_on = 1'b1;
    load(IMG);
    wait_on(0, 1000);
    do_reset(1'b0, 1'b1);
    break_load();
    tick(900);
    chk1("status pull", 1'b1, st_oe);
    chk1("done pull", 1'b1, dn_oe);
    host.pulse_req(2000);
    mon_on = 1'b1;
    load(IMG);
    tick(1000);
    chk1("user mode", 1'b0, umode);
    uclk_run = 1'b1;
    wait_on(0, 3000);
    chk8("bytes left", 8'h00, 8'(exp_q.size()));
    cio = 1'b1;
    cval = 1'($urandom);
    tick(2);
    chk1("chain user io", cval, chain_n);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
